// ---- core/spl_consts.vh ----
// Constants for the servo position parameter logic
`ifndef SPL_CONSTS_VH
`define SPL_CONSTS_VH
`define SPL_POS_W        32
`define SPL_GEAR_W       17
`define SPL_MON_W        16
`define SPL_SEL_W        4
`define SPL_ALM_W        8
`define SPL_SCURVE_W     16
`define SPL_MS_CYCLES    17'd100000
`define SPL_OFFS_MAX     16'sd999
`define SPL_OFFS_MIN     -16'sd999
`define SPL_FULL8V       16'sd8000
`define SPL_FULL10V      16'sd10000
`define SPL_MON_SPEED    4'h0
`define SPL_MON_TORQUE   4'h1
`define SPL_MON_SPEEDABS 4'h2
`define SPL_MON_TORQABS  4'h3
`define SPL_MON_CURCMD   4'h4
`define SPL_MON_SPDCMD   4'h5
`define SPL_MON_DROOP0   4'h6
`define SPL_MON_DROOP1   4'h7
`define SPL_MON_DROOP2   4'h8
`define SPL_MON_DROOP3   4'h9
`define SPL_MON_DROOP4   4'hA
`define SPL_MON_BUSV     4'hB
`define SPL_DROOP_SH0    5'h07
`define SPL_DROOP_SH1    5'h0B
`define SPL_DROOP_SH2    5'h0D
`define SPL_DROOP_SH3    5'h0F
`define SPL_DROOP_SH4    5'h11
`define SPL_BUSV_FULL    16'd400
`define SPL_DISP_DEF     4'h0
`define SPL_EXTDISP_DEF  4'h1
`define SPL_ALM_PARAM    8'h25
`define SPL_ALM_DEPTH    6
`endif

// ---- core/spl_servo_param.v ----
// Position command scaling, monitor outputs, limits and alarm history
// Functional notes
// RULE1 - Scale command pulses by numerator over denominator
// RULE2 - Gear ratio changes apply after power cycle
// RULE3 - Host keeps ratio between 1/10 and 1000
// RULE4 - Carry division remainder, no drift
// RULE5 - Display selection chosen at power-on
// RULE6 - S-curve time delays movement complete
// RULE7 - Two selectable monitor channels
// RULE8 - Signed offset -999..999 mV per channel
// RULE9 - Defaults: speed on one, torque on two
// RULE10 - Codes 0..5 speed, torque, commands
// RULE11 - Codes 6..A droop, B bus voltage
// RULE12 - Default sudden stop at limits
// RULE13 - Stop pattern 0 clears, 1 drains droop
// RULE14 - Keep current plus five past alarms
// RULE15 - Clear digit returns to zero itself
// RULE16 - History clear applies after power cycle
// RULE17 - Beyond soft limit: stop and servo-lock
// RULE18 - Soft limit suspended during homing
// RULE19 - Equal limits disable soft limit
// RULE20 - Plus below minus raises alarm 37
`timescale 1ns/1ps
`include "spl_consts.vh"
module spl_servo_param (
  input  wire                           ref_clk,           // 100 MHz clock
  input  wire                           rst_n,             // Sync reset, active low
  input  wire                           powerOnLoad,       // Power-on latch strobe
  input  wire                           cmdPulseIn,        // Command pulse, async pin
  input  wire                           cmdDirIn,          // Command direction, 1 = negative
  input  wire [`SPL_GEAR_W-1:0]         gearNumerator,     // Gear numerator setting
  input  wire [`SPL_GEAR_W-1:0]         gearDenominator,   // Gear denominator setting
  input  wire [`SPL_SCURVE_W-1:0]       sCurveMs,          // S-curve time constant, ms
  input  wire                           moveDone,          // Profile reached target
  input  wire [`SPL_SEL_W-1:0]          statusDispSel,     // Display selection setting
  input  wire [`SPL_SEL_W-1:0]          monSelOne,         // Channel one selection
  input  wire [`SPL_SEL_W-1:0]          monSelTwo,         // Channel two selection
  input  wire signed [`SPL_MON_W-1:0]   monOffsOne,        // Channel one offset, mV
  input  wire signed [`SPL_MON_W-1:0]   monOffsTwo,        // Channel two offset, mV
  input  wire signed [`SPL_MON_W-1:0]   motorSpeed,        // Speed, full scale 8000
  input  wire signed [`SPL_MON_W-1:0]   motorTorque,       // Torque, full scale 8000
  input  wire signed [`SPL_MON_W-1:0]   currentCmd,        // Current command, 8000 max
  input  wire signed [`SPL_MON_W-1:0]   speedCmd,          // Speed command, 8000 max
  input  wire [`SPL_MON_W-1:0]          busVoltage,        // Bus voltage in volts
  input  wire signed [`SPL_POS_W-1:0]   droopPulses,       // Droop pulse count
  input  wire                           stopPattern,       // 0 sudden, 1 slow stop
  input  wire                           hwLimitHit,        // Stroke end, async pin
  input  wire                           homingActive,      // Home return in progress
  input  wire signed [`SPL_POS_W-1:0]   currentPos,        // Current position
  input  wire signed [`SPL_POS_W-1:0]   softLimitPos,      // Soft limit plus
  input  wire signed [`SPL_POS_W-1:0]   softLimitNeg,      // Soft limit minus
  input  wire                           alarmEvent,        // New alarm strobe
  input  wire [`SPL_ALM_W-1:0]          alarmCode,         // New alarm code
  input  wire                           histClearSet,      // Clear digit written
  input  wire [2:0]                     histIndex,         // History read index
  output reg  signed [`SPL_POS_W-1:0]   scaledPos_reg,     // Scaled command position
  output reg                            scaledStep_reg,    // Scaled step pulse
  output reg                            movementComplete_reg, // Movement complete
  output reg  [`SPL_SEL_W-1:0]          dispSel_reg,       // Local display item
  output reg  [`SPL_SEL_W-1:0]          extDispSel_reg,    // External display item
  output reg  signed [`SPL_MON_W-1:0]   monitorChannelOne_reg, // Monitor one, mV
  output reg  signed [`SPL_MON_W-1:0]   monitorChannelTwo_reg, // Monitor two, mV
  output reg                            stopActive_reg,    // Stop and servo-lock
  output reg                            droopClear_reg,    // Clear droop pulses
  output reg                            droopDrain_reg,    // Drain droop pulses
  output reg                            parameterErrorAlarm_reg, // Alarm 37 active
  output reg  [`SPL_ALM_W-1:0]          alarmRead_reg,     // Selected history entry
  output reg                            histClearDigit_reg // Clear digit readback
);
  // Synchronisers for pins
  reg [1:0] pulseSync_reg;
  reg [1:0] limSync_reg;
  reg       pulseLast_reg;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pulseSync_reg <= 2'h0;
      limSync_reg   <= 2'h0;
      // Edge detector starts low, matching the idle pin
      pulseLast_reg <= 1'b0;
    end else begin
      pulseSync_reg <= {pulseSync_reg[0], cmdPulseIn};
      limSync_reg   <= {limSync_reg[0], hwLimitHit};
      pulseLast_reg <= pulseSync_reg[1];
    end
  end
  wire pulseEdge = pulseSync_reg[1] & ~pulseLast_reg;

  // Gear ratio latched only on power-on strobe
  reg [`SPL_GEAR_W-1:0] gearNum_reg;
  reg [`SPL_GEAR_W-1:0] gearDen_reg;
  reg [`SPL_GEAR_W+1:0] gearAcc_reg;
  reg [`SPL_GEAR_W+1:0] gearAcc_next;
  reg                   stepTake;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      gearNum_reg <= {{(`SPL_GEAR_W-1){1'b0}}, 1'b1};
      gearDen_reg <= {{(`SPL_GEAR_W-1){1'b0}}, 1'b1};
    end else if (powerOnLoad) begin
      gearNum_reg <= gearNumerator; // RULE2
      // Denominator 0 read as 1, the divider never stalls
      gearDen_reg <= (gearDenominator == {`SPL_GEAR_W{1'b0}}) ?
                     {{(`SPL_GEAR_W-1){1'b0}}, 1'b1} : gearDenominator; // RULE2
    end
  end

  // One output step per cycle while accumulator holds a whole unit
  always @* begin
    gearAcc_next = gearAcc_reg;
    stepTake     = 1'b0;
    if (pulseEdge)
      gearAcc_next = gearAcc_next + {2'h0, gearNum_reg}; // RULE1
    // At most one step per cycle; a large ratio leaves a backlog here
    if (gearAcc_next >= {2'h0, gearDen_reg}) begin
      gearAcc_next = gearAcc_next - {2'h0, gearDen_reg}; // RULE4
      stepTake     = 1'b1; // RULE1
    end
  end
  always @(posedge ref_clk) begin
    if (!rst_n || powerOnLoad) begin
      gearAcc_reg    <= {(`SPL_GEAR_W+2){1'b0}};
      scaledPos_reg  <= {`SPL_POS_W{1'b0}};
      scaledStep_reg <= 1'b0;
    end else begin
      gearAcc_reg    <= gearAcc_next; // RULE4
      scaledStep_reg <= stepTake; // RULE1
      if (stepTake && !stopActive_reg)
        scaledPos_reg <= cmdDirIn ? scaledPos_reg - 1 : scaledPos_reg + 1; // RULE1
    end
  end

  // S-curve extends completion by the time constant
  reg [16:0]               msDiv_reg;
  reg [`SPL_SCURVE_W-1:0]  sDelay_reg;
  reg                      doneSeen_reg;
  // Free-running ms tick: wait may fall short by up to one ms
  wire msTick = (msDiv_reg == `SPL_MS_CYCLES - 17'd1);
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      msDiv_reg            <= 17'd0;
      sDelay_reg           <= {`SPL_SCURVE_W{1'b0}};
      doneSeen_reg         <= 1'b0;
      movementComplete_reg <= 1'b0;
    end else begin
      msDiv_reg <= msTick ? 17'd0 : msDiv_reg + 17'd1;
      if (!moveDone) begin
        doneSeen_reg         <= 1'b0;
        movementComplete_reg <= 1'b0;
        sDelay_reg           <= sCurveMs; // RULE6
      end else if (!doneSeen_reg) begin
        doneSeen_reg <= 1'b1;
        if (sDelay_reg == {`SPL_SCURVE_W{1'b0}})
          movementComplete_reg <= 1'b1;
      end else if (!movementComplete_reg && msTick) begin
        if (sDelay_reg <= {{(`SPL_SCURVE_W-1){1'b0}}, 1'b1})
          movementComplete_reg <= 1'b1; // RULE6
        sDelay_reg <= sDelay_reg - {{(`SPL_SCURVE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Display items captured at power-on
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      dispSel_reg    <= `SPL_DISP_DEF; // RULE5
      extDispSel_reg <= `SPL_EXTDISP_DEF; // RULE5
    end else if (powerOnLoad) begin
      // Both displays follow the one selection setting
      dispSel_reg    <= statusDispSel; // RULE5
      extDispSel_reg <= statusDispSel;
    end
  end

  // Monitor channels
  // Full scale 10 V over 128, 2048, 8192, 32768 or 131072 pulses
  function [4:0] spl_droop_sh;
    input [`SPL_SEL_W-1:0] sel;
    begin
      case (sel)
        `SPL_MON_DROOP0: spl_droop_sh = `SPL_DROOP_SH0;
        `SPL_MON_DROOP1: spl_droop_sh = `SPL_DROOP_SH1;
        `SPL_MON_DROOP2: spl_droop_sh = `SPL_DROOP_SH2;
        `SPL_MON_DROOP3: spl_droop_sh = `SPL_DROOP_SH3;
        `SPL_MON_DROOP4: spl_droop_sh = `SPL_DROOP_SH4;
        default:         spl_droop_sh = `SPL_DROOP_SH0;
      endcase
    end
  endfunction

  function signed [`SPL_MON_W-1:0] spl_mon;
    input [`SPL_SEL_W-1:0]        sel;
    input signed [`SPL_MON_W-1:0] offs;
    reg signed [`SPL_POS_W+15:0]  v;
    reg signed [`SPL_MON_W-1:0]   o;
    begin
      v = {(`SPL_POS_W+16){1'b0}};
      if (sel == `SPL_MON_SPEED)
        v = motorSpeed; // RULE10
      else if (sel == `SPL_MON_TORQUE)
        v = motorTorque;
      else if (sel == `SPL_MON_SPEEDABS)
        v = motorSpeed[`SPL_MON_W-1] ? -motorSpeed : motorSpeed;
      else if (sel == `SPL_MON_TORQABS)
        v = motorTorque[`SPL_MON_W-1] ? -motorTorque : motorTorque;
      else if (sel == `SPL_MON_CURCMD)
        v = currentCmd;
      else if (sel == `SPL_MON_SPDCMD)
        v = speedCmd;
      else if (sel >= `SPL_MON_DROOP0 && sel <= `SPL_MON_DROOP4)
        v = (droopPulses * `SPL_FULL10V) >>> spl_droop_sh(sel); // RULE11
      else if (sel == `SPL_MON_BUSV)
        v = ({16'h0000, busVoltage} * `SPL_FULL8V) / `SPL_BUSV_FULL; // RULE11
      o = (offs > `SPL_OFFS_MAX) ? `SPL_OFFS_MAX :
          (offs < `SPL_OFFS_MIN) ? `SPL_OFFS_MIN : offs; // RULE8
      v = v + o; // RULE8
      spl_mon = v[`SPL_MON_W-1:0];
    end
  endfunction
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      monitorChannelOne_reg <= {`SPL_MON_W{1'b0}};
      monitorChannelTwo_reg <= {`SPL_MON_W{1'b0}};
    end else begin
      monitorChannelOne_reg <= spl_mon(monSelOne, monOffsOne); // RULE7 RULE9
      monitorChannelTwo_reg <= spl_mon(monSelTwo, monOffsTwo); // RULE7 RULE9
    end
  end

  // Software and hardware limits
  wire limEqual   = (softLimitPos == softLimitNeg); // RULE19
  wire limInvert  = (softLimitPos < softLimitNeg); // RULE20
  wire softActive = !limEqual && !homingActive; // RULE18
  wire softHit    = softActive && (currentPos > softLimitPos || currentPos < softLimitNeg);
  // Hardware pin lags two cycles behind the soft limit
  wire anyLimit   = limSync_reg[1] | softHit;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      stopActive_reg          <= 1'b0;
      droopClear_reg          <= 1'b0;
      droopDrain_reg          <= 1'b0;
      parameterErrorAlarm_reg <= 1'b0;
    end else begin
      stopActive_reg          <= anyLimit; // RULE17
      droopClear_reg          <= anyLimit && !stopPattern; // RULE12 RULE13
      droopDrain_reg          <= anyLimit && stopPattern; // RULE13
      parameterErrorAlarm_reg <= limInvert; // RULE20
    end
  end

  // Alarm history: entry 0 current, 1..5 past
  reg [`SPL_ALM_W-1:0] almHist_reg [0:`SPL_ALM_DEPTH-1];
  reg                  clearPend_reg;
  // Alarm 37 logged once on its rising edge, not at all if alarmEvent shares that cycle
  wire                 newAlarm = alarmEvent | (limInvert & ~parameterErrorAlarm_reg);
  wire [`SPL_ALM_W-1:0] newCode = alarmEvent ? alarmCode : `SPL_ALM_PARAM;
  genvar gi;
  generate
    for (gi = 0; gi < `SPL_ALM_DEPTH; gi = gi + 1) begin : g_hist
      if (gi == 0) begin : g_new
        // A new alarm in the clearing cycle is kept, not lost
        always @(posedge ref_clk) begin
          if (!rst_n)
            almHist_reg[gi] <= {`SPL_ALM_W{1'b0}};
          else if (powerOnLoad && clearPend_reg)
            almHist_reg[gi] <= newAlarm ? newCode : {`SPL_ALM_W{1'b0}}; // RULE16
          else if (newAlarm)
            almHist_reg[gi] <= newCode; // RULE14
        end
      end else begin : g_old
        always @(posedge ref_clk) begin
          if (!rst_n)
            almHist_reg[gi] <= {`SPL_ALM_W{1'b0}};
          else if (powerOnLoad && clearPend_reg)
            almHist_reg[gi] <= {`SPL_ALM_W{1'b0}}; // RULE16
          else if (newAlarm)
            almHist_reg[gi] <= almHist_reg[gi-1]; // RULE14
        end
      end
    end
  endgenerate
  // History is cleared by reset, and by powerOnLoad once a clear request is pending
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      clearPend_reg      <= 1'b0;
      histClearDigit_reg <= 1'b0;
      alarmRead_reg      <= {`SPL_ALM_W{1'b0}};
    end else begin
      if (histClearSet)
        clearPend_reg <= 1'b1; // RULE16
      else if (powerOnLoad)
        clearPend_reg <= 1'b0; // RULE15
      if (histClearSet)
        histClearDigit_reg <= 1'b1;
      else if (powerOnLoad && clearPend_reg)
        histClearDigit_reg <= 1'b0; // RULE15
      // Indices beyond the history read as zero
      alarmRead_reg <= (histIndex < `SPL_ALM_DEPTH) ? almHist_reg[histIndex] :
                       {`SPL_ALM_W{1'b0}}; // RULE14
    end
  end
endmodule

// ---- verification/spl_host_model.sv ----
// Host model that writes gear, power cycle and history clear settings
`timescale 1ns/1ps
module spl_host_model (
  input  wire        ref_clk,         // Clock
  output reg  [16:0] gearNumerator,   // Gear numerator setting
  output reg  [16:0] gearDenominator, // Gear denominator setting
  output reg         powerOnLoad,     // Power cycle strobe
  output reg         histClearSet     // Clear digit write
);
  initial begin
    gearNumerator = 17'h00001;
    gearDenominator = 17'h00001;
    powerOnLoad = 1'b0;
    histClearSet = 1'b0;
  end
  // Out-of-range ratios are dropped, the old setting stays
  task automatic set_gear(input int n, input int d);
    @(posedge ref_clk);
    if (n * 10 > d && n < d * 1000) begin
      gearNumerator <= n[16:0];
      gearDenominator <= d[16:0];
    end
  endtask
  // Clear request needs a power cycle after it to act
  task automatic pulse(input bit clr);
    @(posedge ref_clk);
    if (clr) histClearSet <= 1'b1;
    else powerOnLoad <= 1'b1;
    @(posedge ref_clk);
    histClearSet <= 1'b0;
    powerOnLoad <= 1'b0;
  endtask
endmodule

// ---- verification/spl_servo_param_monitor.sv ----
// Checker for the servo position parameter logic
`timescale 1ns/1ps
`include "spl_consts.vh"
module spl_servo_param_monitor (
  input wire               ref_clk,                 // Clock
  input wire               rst_n,                   // Reset
  input wire               powerOnLoad,             // Power cycle
  input wire               histClearSet,            // Clear write
  input wire               moveDone,                // Profile done
  input wire        [15:0] sCurveMs,                // S-curve ms
  input wire        [3:0]  monSelOne,               // Select one
  input wire        [3:0]  monSelTwo,               // Select two
  input wire signed [15:0] monOffsOne,              // Offset one
  input wire signed [15:0] monOffsTwo,              // Offset two
  input wire signed [15:0] motorSpeed,              // Speed
  input wire        [15:0] busVoltage,              // Bus volts
  input wire               stopPattern,             // Stop kind
  input wire               homingActive,            // Homing
  input wire signed [31:0] currentPos,              // Position
  input wire signed [31:0] softLimitPos,            // Limit plus
  input wire signed [31:0] softLimitNeg,            // Limit minus
  input wire               movementComplete_reg,    // Complete
  input wire signed [15:0] monitorChannelOne_reg,   // Monitor one
  input wire signed [15:0] monitorChannelTwo_reg,   // Monitor two
  input wire               stopActive_reg,          // Stop
  input wire               droopClear_reg,          // Clear droop
  input wire               droopDrain_reg,          // Drain droop
  input wire               parameterErrorAlarm_reg, // Alarm
  input wire               histClearDigit_reg       // Clear digit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_outside;
    !homingActive && softLimitPos != softLimitNeg &&
    (currentPos > softLimitPos || currentPos < softLimitNeg);
  endsequence
  sequence s_clear_applied;
    histClearDigit_reg && powerOnLoad && !histClearSet;
  endsequence
  a_soft_stop: assert property (s_outside |=> stopActive_reg)
    else $error("soft limit stop missing");
  a_alarm_raise: assert property (softLimitPos < softLimitNeg |=> parameterErrorAlarm_reg)
    else $error("limit alarm missing");
  a_alarm_quiet: assert property (softLimitPos >= softLimitNeg |=> !parameterErrorAlarm_reg)
    else $error("limit alarm without cause");
  a_stop_kind: assert property (stopActive_reg |->
    droopDrain_reg == $past(stopPattern) && droopClear_reg != $past(stopPattern))
    else $error("stop pattern wrong");
  a_mon_bus: assert property (monSelOne == `SPL_MON_BUSV |=> int'(monitorChannelOne_reg)
    == int'($past(busVoltage)) * 20 + int'($past(monOffsOne)))
    else $error("bus voltage monitor wrong");
  a_mon_speed: assert property (monSelTwo == `SPL_MON_SPEED |=>
    monitorChannelTwo_reg == $past(motorSpeed) + $past(monOffsTwo))
    else $error("speed monitor wrong");
  a_done_fast: assert property (moveDone && sCurveMs == 0 |=> movementComplete_reg)
    else $error("movement complete late");
  a_done_fall: assert property (!moveDone |=> !movementComplete_reg)
    else $error("movement complete stuck");
  a_digit_set: assert property (histClearSet |=> histClearDigit_reg)
    else $error("clear digit not set");
  a_digit_hold: assert property (histClearDigit_reg && !powerOnLoad |=> histClearDigit_reg)
    else $error("clear digit dropped early");
  a_digit_back: assert property (s_clear_applied |-> ##[1:2] !histClearDigit_reg)
    else $error("clear digit not returned");
endmodule
bind spl_servo_param spl_servo_param_monitor u_mon (.*);

// ---- verification/tb.sv ----
// Self-checking testbench for the servo position parameter logic
`timescale 1ns/1ps
module tb;
  logic ref_clk = 0, rst_n = 0, cmdPulseIn = 0, cmdDirIn = 0, moveDone = 0, stopPattern = 0;
  logic hwLimitHit = 0, homingActive = 0, alarmEvent = 0;
  logic [15:0] sCurveMs = 0, busVoltage = 0;
  logic [3:0] statusDispSel = 0, monSelOne = 0, monSelTwo = 1;
  logic signed [15:0] monOffsOne = 0, monOffsTwo = 0, motorSpeed = 0, motorTorque = 0;
  logic signed [15:0] currentCmd = 0, speedCmd = 0;
  logic signed [31:0] droopPulses = 0, currentPos = 0, softLimitPos = 0, softLimitNeg = 0;
  logic [7:0] alarmCode = 0;
  logic [2:0] histIndex = 0;
  wire [16:0] gearNumerator, gearDenominator;
  wire powerOnLoad, histClearSet, scaledStep_reg, movementComplete_reg, stopActive_reg;
  wire droopClear_reg, droopDrain_reg, parameterErrorAlarm_reg, histClearDigit_reg;
  wire signed [31:0] scaledPos_reg;
  wire [3:0] dispSel_reg, extDispSel_reg;
  wire signed [15:0] monitorChannelOne_reg, monitorChannelTwo_reg;
  wire [7:0] alarmRead_reg;
  int n_mismatch = 0, checks = 0, num, den, p0, nStep = 0, s0;
  bit sp;
  spl_servo_param u_dut (.*);
  spl_host_model u_host (.*);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (scaledStep_reg) nStep++;
  task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic pulses(int n);
    repeat (n) begin
      @(posedge ref_clk);
      cmdPulseIn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      cmdPulseIn <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    settle(8);
  endtask
  // Droop full scale 10 V over 128, 2048, 8192, 32768, 131072 pulses
  function automatic logic signed [15:0] mon_exp(logic [3:0] s, int off);
    int v;
    case (s)
      0: v = motorSpeed;
      1: v = motorTorque;
      2: v = motorSpeed < 0 ? -motorSpeed : motorSpeed;
      3: v = motorTorque < 0 ? -motorTorque : motorTorque;
      4: v = currentCmd;
      5: v = speedCmd;
      11: v = busVoltage * 20;
      default: v = (droopPulses * 10000) >>> (s == 6 ? 7 : 2 * s - 3);
    endcase
    return 16'(v + off);
  endfunction
  task automatic lim(int p, int n, int c, bit h, logic st, logic al);
    @(posedge ref_clk);
    softLimitPos <= p;
    softLimitNeg <= n;
    currentPos <= c;
    homingActive <= h;
    settle(2);
    cmp("stop", st, stopActive_reg);
    cmp("alarm", al, parameterErrorAlarm_reg);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    void'($urandom(33289));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle(1);
    cmp("display", 4'h0, dispSel_reg);
    cmp("ext display", 4'h1, extDispSel_reg);
    den = $urandom_range(50, 1);
    num = den + $urandom_range(2 * den);
    u_host.set_gear(num, den);
    settle(1);
    p0 = scaledPos_reg;
    pulses(5);
    cmp("position before power cycle", p0 + 5, scaledPos_reg);
    statusDispSel <= $urandom_range(15);
    u_host.pulse(0);
    settle(1);
    cmp("display sel", statusDispSel, dispSel_reg);
    p0 = scaledPos_reg;
    s0 = nStep;
    pulses(20);
    cmp("scaled position", p0 + 20 * num / den, scaledPos_reg);
    cmp("steps", 20 * num / den, nStep - s0);
    for (int i = 0; i < 48; i++) begin
      @(posedge ref_clk);
      monSelOne <= i % 12;
      monSelTwo <= $urandom_range(11);
      monOffsOne <= (i < 2) ? 999 - 1998 * i : $urandom_range(1998) - 999;
      monOffsTwo <= $urandom_range(1998) - 999;
      motorSpeed <= $urandom_range(16000) - 8000;
      motorTorque <= $urandom_range(16000) - 8000;
      currentCmd <= $urandom_range(16000) - 8000;
      speedCmd <= $urandom_range(16000) - 8000;
      droopPulses <= $urandom_range(254) - 127;
      busVoltage <= $urandom_range(400);
      moveDone <= i[2];
      settle(1);
      cmp("monitor one", mon_exp(monSelOne, monOffsOne), monitorChannelOne_reg);
      cmp("monitor two", mon_exp(monSelTwo, monOffsTwo), monitorChannelTwo_reg);
      cmp("complete", moveDone, movementComplete_reg);
    end
    lim(1000, -1000, 500, 0, 0, 0);
    lim(1000, -1000, 1500, 1, 0, 0);
    lim(700, 700, 1500, 0, 0, 0);
    lim(-5, 5, 0, 1, 0, 1);
    cmp("alarm logged", 8'h25, alarmRead_reg);
    sp = $urandom_range(1);
    stopPattern <= sp;
    lim(1000, -1000, -1500, 0, 1, 0);
    cmp("drain", sp, droopDrain_reg);
    stopPattern <= 1'b0;
    currentPos <= 0;
    hwLimitHit <= 1'b1;
    do_reset();
    settle(5);
    cmp("hw stop", 1'b1, stopActive_reg);
    cmp("sudden stop", 1'b1, droopClear_reg);
    hwLimitHit <= 1'b0;
    do_reset();
    for (int i = 1; i <= 6; i++) begin
      @(posedge ref_clk);
      alarmEvent <= 1'b1;
      alarmCode <= 8'(8'h10 + i);
      @(posedge ref_clk);
      alarmEvent <= 1'b0;
    end
    for (int k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      histIndex <= k;
      settle(2);
      cmp("history", 8'h16 - k, alarmRead_reg);
    end
    histIndex <= 3'h0;
    u_host.pulse(1);
    settle(2);
    cmp("clear digit", 1'b1, histClearDigit_reg);
    cmp("history kept", 8'h16, alarmRead_reg);
    u_host.pulse(0);
    settle(3);
    cmp("clear digit back", 1'b0, histClearDigit_reg);
    cmp("history cleared", 8'h00, alarmRead_reg);
    conclude();
  end
endmodule
